// *** logic/prxb_pkg.sv ***
package prxb_pkg;

  // ==========================================================================
  // Geometry
  localparam int MEMS   = 2;
  localparam int LANES  = 2;
  localparam int BUFS   = 8;
  localparam int SEL_W  = 3;
  localparam int DEPTH  = 16;
  localparam int PTR_W  = 4;

  // ==========================================================================
  // Burst shape and timing
  localparam logic [2:0]       NARROW_LAST = 3'h3;
  localparam logic [2:0]       WIDE_LAST   = 3'h1;
  localparam logic [2:0]       PAUSE_LAST  = 3'h1;
  localparam logic [2:0]       BEAT_FIRST  = 3'h0;
  localparam logic [PTR_W:0]   FILL_LIMIT  = 5'h10;
  localparam logic [PTR_W:0]   PTR_STEP    = 5'h01;
  localparam logic [7:0]       ID_BV       = 8'h01;
  localparam logic [3:0]       FULL_BV     = 4'hf;
  localparam logic [3:0]       NONE_BV     = 4'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  bv;
    logic        sop;
    logic        eop;
    logic        err;
    logic [7:0]  port;
  } prxb_word_t;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  bv;
    logic        marker;
    logic        sop;
    logic        eop;
    logic        err;
  } prxb_out_t;

  typedef enum logic [1:0] {S_IDLE, S_ID, S_DATA, S_PAUSE} prxb_state_t;

endpackage : prxb_pkg

// *** logic/prxb_skid2.sv ***
`timescale 1ns/1ps
module prxb_skid2 #(
  parameter int W = 8
) (
  // Clock and reset
  input  logic         sys_clk,
  input  logic         sys_rst,
  // Fill side
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  // Drain side
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  localparam logic [1:0] CNT_FULL = 2'h2;
  localparam logic [1:0] CNT_ONE  = 2'h1;

  logic [W-1:0] slot_reg [2];
  logic         wr_reg;
  logic         rd_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pull;

  assign in_ready  = (cnt_reg != CNT_FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = slot_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pull      = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= !wr_reg;
      if (pull) rd_reg <= !rd_reg;
      if (push && !pull) cnt_reg <= cnt_reg + CNT_ONE;
      else if (pull && !push) cnt_reg <= cnt_reg - CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) slot_reg[wr_reg] <= in_data;
  end

endmodule : prxb_skid2

// *** logic/prxb_read_port.sv ***
// Operation
// - In wide mode memories zero and one act as one combined memory.
// - In wide mode data leaves as bursts of two 64-bit words, led by a port-ID cycle when due.
// - An end of packet on the first word of a wide burst cuts the burst and moves on.
// - Read enable and address go in together; port ID comes two cycles later, then the data.
// - In wide mode the port ID sits in the low byte with byte valid 00000001.
// - In narrow mode the first word, port ID or data, appears two cycles after read enable.
// - In narrow mode a port-ID word is followed by four-word bursts from the read pointer.
// - With pause high, two idle cycles with all byte valids low follow each end of packet.
// - The ID marker is high on the port-ID word and the ID is skipped for the same port.
// - An address without read enable returns empty status and removes nothing.
`timescale 1ns/1ps
module prxb_read_port
  import prxb_pkg::*;
(
  // Clock and reset
  input  logic                                   sys_clk,
  input  logic                                   sys_rst,
  // Mode
  input  logic                                   wide_mode,
  // Receive side fill, one port per buffer memory
  input  logic [prxb_pkg::MEMS-1:0]              buf_wr_valid,
  output logic [prxb_pkg::MEMS-1:0]              buf_wr_ready,
  input  logic [prxb_pkg::MEMS-1:0][prxb_pkg::SEL_W-1:0] buf_wr_select,
  input  prxb_pkg::prxb_word_t [prxb_pkg::MEMS-1:0]      buf_wr_word,
  // Narrow lanes
  input  logic [prxb_pkg::LANES-1:0]             narrow_lane_read_enable,
  input  logic [prxb_pkg::LANES-1:0][prxb_pkg::SEL_W-1:0] narrow_lane_buffer_select,
  // Wide lane, served by lane 0
  input  logic                                   wide_lane_read_enable,
  input  logic [prxb_pkg::SEL_W-1:0]             wide_lane_buffer_select,
  // Per lane controls and results
  input  logic [prxb_pkg::LANES-1:0]             pause_after_packet_end,
  input  logic [prxb_pkg::LANES-1:0]             lane_accept,
  output logic [prxb_pkg::LANES-1:0]             lane_word_valid,
  output prxb_pkg::prxb_out_t [prxb_pkg::LANES-1:0]      lane_read_out,
  output logic [prxb_pkg::LANES-1:0]             narrow_lane_buffer_empty
);
  import prxb_pkg::*;

  // ==========================================================================
  // Buffer memories and pointers
  prxb_word_t       mem_reg [MEMS][BUFS][DEPTH];
  logic [PTR_W:0]   wp_reg  [MEMS][BUFS];
  logic [PTR_W:0]   rp_reg  [MEMS][BUFS];
  logic [LANES-1:0] pop_w;
  logic [SEL_W-1:0] pop_sel_w [LANES];

  function automatic logic buf_empty(input int m, input logic [SEL_W-1:0] s);
    buf_empty = (wp_reg[m][s] == rp_reg[m][s]);
  endfunction : buf_empty

  function automatic logic buf_one(input int m, input logic [SEL_W-1:0] s);
    buf_one = ((wp_reg[m][s] - rp_reg[m][s]) == PTR_STEP);
  endfunction : buf_one

  genvar m, b, l;
  generate
    for (m = 0; m < MEMS; m++) begin : g_mem
      logic [PTR_W:0] wp_sel;
      logic [PTR_W:0] rp_sel;
      logic           wr_fire;
      assign wp_sel          = wp_reg[m][buf_wr_select[m]];
      assign rp_sel          = rp_reg[m][buf_wr_select[m]];
      assign buf_wr_ready[m] = ((wp_sel - rp_sel) != FILL_LIMIT);
      assign wr_fire         = buf_wr_valid[m] && buf_wr_ready[m];

      always_ff @(posedge sys_clk) begin
        if (wr_fire) mem_reg[m][buf_wr_select[m]][wp_sel[PTR_W-1:0]] <= buf_wr_word[m];
      end

      for (b = 0; b < BUFS; b++) begin : g_buf
        logic pop_here;
        // In wide mode lane 0 pops the same slot of both memories together
        assign pop_here = (pop_w[m] && pop_sel_w[m] == b)
                       || (m == 1 && wide_mode && pop_w[0] && pop_sel_w[0] == b);
        always_ff @(posedge sys_clk) begin
          if (sys_rst) begin
            wp_reg[m][b] <= '0;
            rp_reg[m][b] <= '0;
          end else begin
            if (wr_fire && buf_wr_select[m] == b) wp_reg[m][b] <= wp_reg[m][b] + PTR_STEP;
            if (pop_here) rp_reg[m][b] <= rp_reg[m][b] + PTR_STEP;
          end
        end
      end
    end

    // ========================================================================
    // Read engines, one per lane
    for (l = 0; l < LANES; l++) begin : g_lane
      prxb_state_t      st_reg, st_next;
      logic [SEL_W-1:0] sel_reg, sel_next;
      logic [2:0]       beat_reg, beat_next;
      logic [7:0]       last_port_reg, last_port_next;
      logic             port_ok_reg, port_ok_next;
      logic             empty_reg;
      logic             use_wide, active, rd_en, emp_in, emp_cur, same_pop, emp_go;
      logic [PTR_W:0]   hd_ptr;
      logic             start_ok, start_id, emit, fill_ready, fire, burst_end;
      logic [SEL_W-1:0] sel_in;
      logic [2:0]       last_beat;
      prxb_word_t       hd_in, e0, e1;
      prxb_out_t        id_word, data_word, fill_word;

      assign use_wide  = wide_mode && (l == 0);
      assign active    = !(wide_mode && l == 1);
      assign rd_en     = use_wide ? wide_lane_read_enable : narrow_lane_read_enable[l];
      assign sel_in    = use_wide ? wide_lane_buffer_select : narrow_lane_buffer_select[l];
      assign emp_in    = buf_empty(l, sel_in) || (use_wide && buf_empty(1, sel_in));
      assign emp_cur   = buf_empty(l, sel_reg) || (use_wide && buf_empty(1, sel_reg));
      // A pop from the addressed buffer in this cycle hides its head word and may drain it;
      // without this a restart at a burst end would latch an empty buffer or a stale port
      assign same_pop  = pop_w[l] && (sel_in == sel_reg);
      assign hd_ptr    = rp_reg[l][sel_in] + (same_pop ? PTR_STEP : '0);
      assign hd_in     = mem_reg[l][sel_in][hd_ptr[PTR_W-1:0]];
      assign emp_go    = emp_in || (same_pop && (buf_one(l, sel_in)
                      || (use_wide && buf_one(1, sel_in))));
      assign e0        = mem_reg[l][sel_reg][rp_reg[l][sel_reg][PTR_W-1:0]];
      assign e1        = mem_reg[1][sel_reg][rp_reg[1][sel_reg][PTR_W-1:0]];
      assign last_beat = use_wide ? WIDE_LAST : NARROW_LAST;
      assign start_ok  = active && rd_en && !emp_go;
      // Repeat reads of the same port skip the identifier
      assign start_id  = !port_ok_reg || (hd_in.port != last_port_reg);

      // Identifier word: low byte, single byte valid, marker set
      always_comb begin
        id_word        = '0;
        id_word.data   = {56'h0, e0.port};
        id_word.bv     = ID_BV;
        id_word.marker = 1'b1;
      end

      // Data word; a packet end in the low half leaves the high half unused
      always_comb begin
        data_word      = '0;
        data_word.sop  = e0.sop;
        data_word.err  = e0.err || (use_wide && e1.err);
        data_word.eop  = e0.eop || (use_wide && e1.eop);
        if (use_wide) begin
          data_word.data = {e1.data, e0.data};
          data_word.bv   = {e0.eop ? NONE_BV : (e1.eop ? e1.bv : FULL_BV),
                            e0.eop ? e0.bv : FULL_BV};
        end else begin
          data_word.data = {32'h0, e0.data};
          data_word.bv   = {NONE_BV, e0.eop ? e0.bv : FULL_BV};
        end
      end

      assign emit = (st_reg == S_ID) || (st_reg == S_PAUSE)
                 || (st_reg == S_DATA && !emp_cur);
      // Idle cycles are all-zero words with no byte valid
      assign fill_word = (st_reg == S_ID)   ? id_word :
                         (st_reg == S_DATA) ? data_word : '0;
      assign fire      = emit && fill_ready;
      assign pop_w[l]     = (st_reg == S_DATA) && fire;
      assign pop_sel_w[l] = sel_reg;
      assign burst_end = pop_w[l] && (data_word.eop || beat_reg == last_beat);

      always_comb begin
        st_next        = st_reg;
        sel_next       = sel_reg;
        beat_next      = beat_reg;
        last_port_next = last_port_reg;
        port_ok_next   = port_ok_reg;
        case (st_reg)
          S_ID: begin
            if (fire) begin
              st_next        = S_DATA;
              beat_next      = BEAT_FIRST;
              last_port_next = e0.port;
              port_ok_next   = 1'b1;
            end
          end
          S_DATA: begin
            if (pop_w[l]) beat_next = beat_reg + 3'h1;
            if (burst_end && data_word.eop && pause_after_packet_end[l]) begin
              st_next   = S_PAUSE;
              beat_next = BEAT_FIRST;
            end else if (burst_end) begin
              st_next = S_IDLE;
            end
          end
          S_PAUSE: begin
            if (fire) beat_next = beat_reg + 3'h1;
            if (fire && beat_reg == PAUSE_LAST) st_next = S_IDLE;
          end
          default: st_next = S_IDLE;
        endcase
        // A new address taken at a burst end hides the start-up latency
        if ((st_next == S_IDLE) && start_ok && (st_reg == S_IDLE || burst_end)) begin
          sel_next  = sel_in;
          beat_next = BEAT_FIRST;
          st_next   = start_id ? S_ID : S_DATA;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          st_reg        <= S_IDLE;
          sel_reg       <= '0;
          beat_reg      <= BEAT_FIRST;
          last_port_reg <= '0;
          port_ok_reg   <= 1'b0;
          empty_reg     <= 1'b1;
        end else begin
          st_reg        <= st_next;
          sel_reg       <= sel_next;
          beat_reg      <= beat_next;
          last_port_reg <= last_port_next;
          port_ok_reg   <= port_ok_next;
          empty_reg     <= emp_in;
        end
      end

      assign narrow_lane_buffer_empty[l] = empty_reg;

      // Two entries absorb a receiver stall without losing the word in flight
      prxb_skid2 #(.W($bits(prxb_out_t))) u_skid (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (emit),
        .in_ready  (fill_ready),
        .in_data   (fill_word),
        .out_valid (lane_word_valid[l]),
        .out_ready (lane_accept[l]),
        .out_data  (lane_read_out[l])
      );

      // ======================================================================
      // Checks
      a_wide_pair_pop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (use_wide && pop_w[l]) |=> (rp_reg[1][$past(sel_reg)] == $past(rp_reg[1][sel_reg]) + PTR_STEP))
        else $error("wide pop did not advance both memories");
      a_wide_burst_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (use_wide && st_reg == S_DATA) |-> beat_reg <= WIDE_LAST)
        else $error("wide burst longer than two words");
      a_eop_cuts_burst: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pop_w[l] && data_word.eop && !pause_after_packet_end[l]) |=> st_reg != S_DATA
          || beat_reg == BEAT_FIRST)
        else $error("burst kept going after end of packet");
      a_read_latency: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_reg == S_IDLE && start_ok && !lane_word_valid[l] && lane_accept[l])
          |-> ##2 lane_word_valid[l])
        else $error("first word not two cycles after read enable");
      a_id_byte_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (lane_word_valid[l] && lane_read_out[l].marker) |-> lane_read_out[l].bv == ID_BV)
        else $error("port ID word with wrong byte valid");
      a_narrow_burst_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_reg == S_DATA) |-> beat_reg <= NARROW_LAST)
        else $error("narrow burst longer than four words");
      a_pause_two_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pop_w[l] && data_word.eop && pause_after_packet_end[l] && fill_ready)
          |=> (st_reg == S_PAUSE && fill_word.bv == '0) ##1 (st_reg == S_PAUSE))
        else $error("idle cycles missing after end of packet");
      a_data_no_marker: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pop_w[l] |-> !fill_word.marker)
        else $error("marker raised on a data word");
      a_status_no_pop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_reg == S_IDLE && !rd_en) |-> ##1 !pop_w[l])
        else $error("status poll removed data");
      a_full_bytes: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pop_w[l] && !data_word.eop) |-> fill_word.bv[3:0] == FULL_BV)
        else $error("non-final word with partial byte valid");

      c_id_then_data: cover property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg == S_ID ##1 st_reg == S_DATA);
      c_pause_taken: cover property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg == S_PAUSE);
      c_wide_cut: cover property (@(posedge sys_clk) disable iff (sys_rst)
        use_wide && pop_w[l] && e0.eop && beat_reg == BEAT_FIRST);
      c_stall_full: cover property (@(posedge sys_clk) disable iff (sys_rst)
        emit && !fill_ready);
    end
  endgenerate

endmodule : prxb_read_port

// *** bench/prxb_reader_model.sv ***
`timescale 1ns/1ps
module prxb_reader_model (
  // Clock and reset
  input  logic                       sys_clk,
  input  logic                       sys_rst,
  // Pace and handshake
  input  logic                       slow,
  output logic [prxb_pkg::LANES-1:0] lane_accept
);
  import prxb_pkg::*;
  // ====================================================================
  // Receiver pacing
  // Own LFSR, so that the stall pattern leaves the bench seed alone
  logic [7:0] lfsr_reg = 8'h5a;
  always @(posedge sys_clk) begin
    #1;
    lfsr_reg = sys_rst ? 8'h5a : {lfsr_reg[6:0], ^(lfsr_reg & 8'hb8)};
    lane_accept = slow ? lfsr_reg[LANES-1:0] : '1;
  end
endmodule : prxb_reader_model

// *** bench/prxb_read_port_bench.sv ***
`timescale 1ns/1ps
module prxb_read_port_bench;
  import prxb_pkg::*;
  // ====================================================================
  // Stimulus and bookkeeping
  logic                        sys_clk = 1'b0;
  logic                        sys_rst = 1'b1;
  logic                        wide_mode = 1'b0;
  logic [MEMS-1:0]             buf_wr_valid = '0;
  logic [MEMS-1:0]             buf_wr_ready;
  logic [MEMS-1:0][SEL_W-1:0]  buf_wr_select = '0;
  prxb_word_t [MEMS-1:0]       buf_wr_word = '0;
  logic [LANES-1:0]            narrow_lane_read_enable = '0;
  logic [LANES-1:0][SEL_W-1:0] narrow_lane_buffer_select = '0;
  logic                        wide_lane_read_enable = 1'b0;
  logic [SEL_W-1:0]            wide_lane_buffer_select = '0;
  logic [LANES-1:0]            pause_after_packet_end = '0;
  logic [LANES-1:0]            lane_accept;
  logic [LANES-1:0]            lane_word_valid;
  prxb_out_t [LANES-1:0]       lane_read_out;
  logic [LANES-1:0]            narrow_lane_buffer_empty;
  logic                        slow = 1'b0;
  logic [8:0]                  last_port [LANES];
  prxb_out_t                   exp_q [LANES][$];
  prxb_out_t                   got_q [LANES][$];
  int                          bad_count = 0;
  int                          n_compared = 0;
  int                          cycles = 0;
  int                          seed = 41;
  always #25 sys_clk = ~sys_clk;

  prxb_read_port prxb_read_port_i (
    .sys_clk, .sys_rst, .wide_mode, .buf_wr_valid, .buf_wr_ready, .buf_wr_select,
    .buf_wr_word, .narrow_lane_read_enable, .narrow_lane_buffer_select,
    .wide_lane_read_enable, .wide_lane_buffer_select, .pause_after_packet_end,
    .lane_accept, .lane_word_valid, .lane_read_out, .narrow_lane_buffer_empty
  );
  prxb_reader_model prxb_reader_model_i (.sys_clk, .sys_rst, .slow, .lane_accept);

  // ====================================================================
  // Checking and reporting
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic compare_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare_bit

  task automatic compare_word(input prxb_out_t got, input prxb_out_t exp);
    logic [63:0] m;
    logic        bad;
    m = exp.bv == NONE_BV ? 64'h0 : exp.marker ? 64'hff : wide_mode ? '1 : 64'hffffffff;
    bad = (got.data & m) !== (exp.data & m) || got.bv !== exp.bv || got.marker !== exp.marker;
    if (m > 64'hff) bad = bad || got.sop !== exp.sop || got.eop !== exp.eop;
    if (exp.eop) bad = bad || got.err !== exp.err;
    n_compared++;
    if (bad) begin
      bad_count++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare_word

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  always @(posedge sys_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (!sys_rst && lane_word_valid[l] === 1'b1 && lane_accept[l]) begin
        got_q[l].push_back(lane_read_out[l]);
      end
    end
  end

  // ====================================================================
  // Drivers and expectations
  task automatic put(input logic [1:0] m, input logic [2:0] sel, input prxb_word_t w0, w1);
    buf_wr_valid = m;
    buf_wr_select = {sel, sel};
    buf_wr_word = {w1, w0};
    #1;
    while ((buf_wr_ready & m) != m) begin
      @(posedge sys_clk);
      #2;
    end
    @(posedge sys_clk);
    #1;
  endtask : put

  // Packet into a buffer; expectation follows the order of reading
  task automatic gen(input int l, input logic [2:0] sel, input logic [7:0] port,
                     input int len, input logic eop_low);
    prxb_word_t w0;
    prxb_word_t w1;
    prxb_out_t  e;
    logic       perr;
    logic [3:0] lbv;
    perr = 1'($random(seed));
    lbv = 4'hf >> ($unsigned($random(seed)) % 4);
    for (int i = 0; i < len; i++) begin
      w0 = '{data: $random(seed), bv: FULL_BV, sop: i == 0, eop: 1'b0, err: perr, port: port};
      w1 = w0;
      w1.data = $random(seed);
      if (i == len - 1) begin
        w1.bv = lbv;
        w0.eop = eop_low || !wide_mode;
        w1.eop = !w0.eop;
        if (w0.eop) w0.bv = lbv;
      end
      put(wide_mode ? 2'h3 : (l == 0 ? 2'h1 : 2'h2), sel, w0, wide_mode ? w1 : w0);
      if ({1'b0, port} != last_port[l]) begin
        e = '0;
        e.data[7:0] = port;
        e.bv = ID_BV;
        e.marker = 1'b1;
        exp_q[l].push_back(e);
        last_port[l] = {1'b0, port};
      end
      e = '0;
      e.data = {w1.data, w0.data};
      e.bv = {(wide_mode && !w0.eop) ? w1.bv : NONE_BV, w0.bv};
      e.sop = w0.sop;
      e.eop = w0.eop || (wide_mode && w1.eop);
      e.err = perr;
      exp_q[l].push_back(e);
      if (e.eop && pause_after_packet_end[l]) begin
        e = '0;
        exp_q[l].push_back(e);
        exp_q[l].push_back(e);
      end
    end
    buf_wr_valid = '0;
    @(posedge sys_clk);
    #1;
  endtask : gen

  task automatic set_rd(input int l, input logic [2:0] sel, input logic on);
    if (wide_mode) begin
      wide_lane_read_enable = on;
      wide_lane_buffer_select = sel;
    end else begin
      narrow_lane_read_enable[l] = on;
      narrow_lane_buffer_select[l] = sel;
    end
  endtask : set_rd

  task automatic run(input int l, input logic [2:0] sel, sel2, input int nsw, input logic lat);
    int n;
    n = exp_q[l].size();
    set_rd(l, sel, 1'b1);
    if (lat) begin
      @(posedge sys_clk);
      #1 compare_bit(lane_word_valid[l], 1'b0);
      @(posedge sys_clk);
      #1 compare_bit(lane_word_valid[l], 1'b1);
    end
    while (got_q[l].size() < n) begin
      @(posedge sys_clk);
      #1;
      if (got_q[l].size() >= nsw) set_rd(l, sel2, 1'b1);
    end
    set_rd(l, sel2, 1'b0);
    repeat (8) @(posedge sys_clk);
    #1 compare_bit(got_q[l].size() == n, 1'b1);
    while (got_q[l].size() > 0 && exp_q[l].size() > 0) begin
      compare_word(got_q[l].pop_front(), exp_q[l].pop_front());
    end
    got_q[l].delete();
    exp_q[l].delete();
  endtask : run

  function automatic logic [7:0] pick();
    return 8'h10 | 8'($random(seed) & 1);
  endfunction : pick

  function automatic int rlen();
    return 1 + $unsigned($random(seed)) % 5;
  endfunction : rlen

  // ====================================================================
  // Main sequence
  initial begin
    last_port = '{9'h100, 9'h100};
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    for (int l = 0; l < LANES; l++) begin
      compare_bit(narrow_lane_buffer_empty[l], 1'b1);
      compare_bit(lane_word_valid[l], 1'b0);
    end
    gen(0, 3'h1, 8'h21, 5, 1'b0);
    run(0, 3'h1, 3'h1, 999, 1'b1);
    $display("test narrow latency done");
    gen(1, 3'h3, 8'h42, 6, 1'b0);
    narrow_lane_buffer_select[1] = 3'h3;
    repeat (3) @(posedge sys_clk);
    #1 compare_bit(narrow_lane_buffer_empty[1], 1'b0);
    narrow_lane_buffer_select[1] = 3'h5;
    repeat (3) @(posedge sys_clk);
    #1 compare_bit(narrow_lane_buffer_empty[1], 1'b1);
    compare_bit(lane_word_valid[1], 1'b0);
    run(1, 3'h3, 3'h3, 999, 1'b0);
    $display("test status poll done");
    for (int k = 0; k < 8; k++) begin
      int l;
      int nsw;
      l = k % 2;
      pause_after_packet_end[l] = 1'($random(seed));
      slow = k[1];
      gen(l, 3'h0, pick(), rlen(), 1'b0);
      gen(l, 3'h0, pick(), rlen(), 1'b0);
      nsw = exp_q[l].size() - 1;
      gen(l, 3'h4, pick(), rlen(), 1'b0);
      run(l, 3'h0, 3'h4, nsw, 1'b0);
    end
    $display("test random narrow done");
    slow = 1'b1;
    pause_after_packet_end = '0;
    gen(0, 3'h2, 8'h33, 16, 1'b0);
    buf_wr_valid = 2'h1;
    #1 compare_bit(buf_wr_ready[0], 1'b0);
    buf_wr_valid = '0;
    @(posedge sys_clk);
    #1 run(0, 3'h2, 3'h2, 999, 1'b0);
    compare_bit(buf_wr_ready[0], 1'b1);
    $display("test fill and drain done");
    sys_rst = 1'b1;
    wide_mode = 1'b1;
    slow = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    last_port = '{9'h100, 9'h100};
    compare_bit(narrow_lane_buffer_empty[0], 1'b1);
    gen(0, 3'h5, 8'h50, 3, 1'b1);
    gen(0, 3'h5, 8'h51, 2, 1'b0);
    run(0, 3'h5, 3'h5, 999, 1'b1);
    slow = 1'b1;
    pause_after_packet_end[0] = 1'b1;
    gen(0, 3'h6, 8'h51, 4, 1'b1);
    gen(0, 3'h6, 8'h52, 1, 1'b1);
    run(0, 3'h6, 3'h6, 999, 1'b0);
    $display("test wide done");
    tally_and_finish();
  end
endmodule : prxb_read_port_bench
